// ---- hw/brpr_bank.sv ----
// Register bank with serial slave for the battery protector
`timescale 1ns/100ps
`default_nettype none
module brpr_bank (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST,
  // Serial link, data pin open drain
  input  wire logic               SCL_I,
  input  wire logic               SDA_I,
  output logic                    SDA_O,
  output logic                    SDA_OE,
  // Comparator levels
  input  wire brpr_pkg::brpr_cmp_t CMP,
  // Protection outputs
  output logic                    ALERT_N,
  output logic                    DISCHARGE_FET_ON,
  output logic                    CHARGE_FET_ON,
  output logic                    PRECHARGE_FET_OFF,
  output logic                    MONITOR_DISABLE,
  output logic                    LED_DRIVE_ENABLE,
  output logic                    THERMISTOR_POWER_ON,
  output logic                    SHUTDOWN_MONITOR_DISABLE,
  // Threshold and selection codes
  output logic [3:0]              SHUTDOWN_THRESHOLD_CODE,
  output logic [3:0]              BROWNOUT_THRESHOLD_CODE,
  output logic [4:0]              DISCHARGE_OVERLOAD_CODE,
  output logic [4:0]              CHARGE_OVERCURRENT_CODE,
  output logic [7:0]              OVERCURRENT_DELAY_SEL,
  output logic [7:0]              MONITOR_BALANCE_SEL,
  output logic [7:0]              SHORT_CIRCUIT_LEVEL,
  output logic [7:0]              SHORT_CIRCUIT_DELAY_SEL
);

  brpr_pkg::brpr_state_t st_q, st_d;
  logic [7:0]            reg_q [1:8];
  logic [3:0]            cnt_q, cnt_d;
  logic [7:0]            sh_q, sh_d;
  logic [7:0]            ptr_q, ptr_d;
  logic [7:0]            tx_q, tx_d;
  logic                  ack_q, ack_d;
  logic                  mack_q, mack_d;
  logic                  oe_q, oe_d;
  logic                  scl_q, sda_q;
  logic                  wr_en, load;
  logic [3:0]            flag_q;
  logic                  alert_q;
  logic                  dsg_q, chg_q, precharge_fet_off_off_q;

  // Bus event decode
  wire scl_rise = SCL_I & ~scl_q;
  wire scl_fall = ~SCL_I & scl_q;
  wire start    = SCL_I & scl_q & sda_q & ~SDA_I;
  wire stop     = SCL_I & scl_q & ~sda_q & SDA_I;

  // Register decode
  wire brpr_pkg::brpr_ctrl_t ctrl = brpr_pkg::brpr_ctrl_t'(reg_q[1]);
  wire [3:0] live      = {CMP.charge_overcurrent, CMP.discharge_overload,
                          CMP.charge_short, CMP.discharge_short};
  wire [7:0] status    = {2'h0, CMP.shutdown, CMP.brownout, flag_q | live};
  wire       in_map    = (ptr_q <= brpr_pkg::SC_DLY_OFS);
  wire       is_status = (ptr_q == brpr_pkg::STATUS_OFS);
  wire [7:0] rd_word   = is_status ? status : (in_map ? reg_q[ptr_q[3:0]] : 8'h00);
  wire       ctrl_wr   = wr_en & (ptr_q == brpr_pkg::CONTROL_OFS);
  wire       release_p = ctrl_wr & ~sh_q[0] & ctrl.latch_release_bit;
  wire       status_rd = load & is_status;
  wire       prot      = |flag_q;
  wire       new_event = |(live & ~flag_q);
  wire       alert_clr = status_rd & ~ctrl.latch_release_bit & ~prot;
  wire       shut_act  = CMP.shutdown & ~ctrl.shutdown_monitor_disable;

  // Serial slave sequencing
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    tx_d   = tx_q;
    ack_d  = ack_q;
    mack_d = mack_q;
    oe_d   = oe_q;
    wr_en  = 1'b0;
    load   = 1'b0;
    if (start) begin
      st_d   = brpr_pkg::ST_ADDR;
      cnt_d  = 4'h0;
      ack_d  = 1'b0;
      mack_d = 1'b0;
      oe_d   = 1'b0;
    end else if (stop) begin
      st_d   = brpr_pkg::ST_IDLE;
      ack_d  = 1'b0;
      mack_d = 1'b0;
      oe_d   = 1'b0;
    end else if (st_q != brpr_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (mack_q) begin
          if (SDA_I) begin
            st_d = brpr_pkg::ST_IDLE;
          end
        end else if (!ack_q) begin
          sh_d  = {sh_q[6:0], SDA_I};
          cnt_d = cnt_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q || mack_q) begin
          ack_d  = 1'b0;
          mack_d = 1'b0;
          oe_d   = 1'b0;
          cnt_d  = 4'h0;
          // Same register every byte, pointer never advances
          if (st_q == brpr_pkg::ST_RD) begin
            load = 1'b1;
            tx_d = rd_word;
            oe_d = ~rd_word[7];
          end
        end else if (cnt_q == brpr_pkg::BYTE_BITS) begin
          unique case (st_q)
            brpr_pkg::ST_ADDR: begin
              // General call and foreign addresses get no ack
              if (sh_q[7:1] == brpr_pkg::SLAVE_ADDR) begin
                ack_d = 1'b1;
                oe_d  = 1'b1;
                st_d  = sh_q[0] ? brpr_pkg::ST_RD : brpr_pkg::ST_PTR;
              end else begin
                st_d = brpr_pkg::ST_IDLE;
              end
            end
            brpr_pkg::ST_PTR: begin
              ptr_d = sh_q;
              ack_d = 1'b1;
              oe_d  = 1'b1;
              st_d  = brpr_pkg::ST_WR;
            end
            brpr_pkg::ST_WR: begin
              wr_en = 1'b1;
              ack_d = 1'b1;
              oe_d  = 1'b1;
            end
            brpr_pkg::ST_RD: begin
              mack_d = 1'b1;
              oe_d   = 1'b0;
            end
            brpr_pkg::ST_IDLE: begin
              st_d = brpr_pkg::ST_IDLE;
            end
          endcase
        end else if (st_q == brpr_pkg::ST_RD) begin
          oe_d = ~tx_q[3'd7 - cnt_q[2:0]];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q   <= brpr_pkg::ST_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      tx_q   <= 8'h00;
      ack_q  <= 1'b0;
      mack_q <= 1'b0;
      oe_q   <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      tx_q   <= tx_d;
      ack_q  <= ack_d;
      mack_q <= mack_d;
      oe_q   <= oe_d;
      scl_q  <= SCL_I;
      sda_q  <= SDA_I;
    end
  end

  // Writable registers; status has no storage so it cannot be written
  for (genvar i = 1; i <= 8; i++) begin : g_reg
    always_ff @(posedge CLK) begin
      if (RST) begin
        reg_q[i] <= brpr_pkg::RESET_VAL;
      end else if (wr_en && ptr_q == 8'(i)) begin
        reg_q[i] <= sh_q & brpr_pkg::WR_MASK[i];
      end
    end
  end

  // Fault latch and alert; a new event wins over release or clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      flag_q  <= 4'h0;
      alert_q <= 1'b0;
    end else begin
      flag_q  <= live | (flag_q & ~{4{release_p}});
      alert_q <= new_event | (alert_q & ~alert_clr);
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      dsg_q      <= 1'b0;
      chg_q      <= 1'b0;
      precharge_fet_off_off_q <= 1'b0;
    end else begin
      dsg_q      <= ctrl.discharge_fet_on & ~prot & ~shut_act;
      chg_q      <= ctrl.charge_fet_on & ~prot & ~shut_act;
      precharge_fet_off_off_q <= ctrl.precharge_fet_off & ~prot;
    end
  end

  assign SDA_O                    = 1'b0;
  assign SDA_OE                   = oe_q;
  assign ALERT_N                  = ~alert_q;
  assign DISCHARGE_FET_ON         = dsg_q;
  assign CHARGE_FET_ON            = chg_q;
  assign PRECHARGE_FET_OFF        = precharge_fet_off_off_q;
  assign MONITOR_DISABLE          = reg_q[1][4];
  assign LED_DRIVE_ENABLE         = reg_q[1][5];
  assign THERMISTOR_POWER_ON      = reg_q[1][6];
  assign SHUTDOWN_MONITOR_DISABLE = reg_q[1][7];
  assign SHUTDOWN_THRESHOLD_CODE  = reg_q[2][brpr_pkg::SHUT_LSB +: 4];
  assign BROWNOUT_THRESHOLD_CODE  = reg_q[2][brpr_pkg::BROWN_LSB +: 4];
  assign DISCHARGE_OVERLOAD_CODE  = reg_q[3][4:0];
  assign CHARGE_OVERCURRENT_CODE  = reg_q[4][4:0];
  assign OVERCURRENT_DELAY_SEL    = reg_q[5];
  assign MONITOR_BALANCE_SEL      = reg_q[6];
  assign SHORT_CIRCUIT_LEVEL      = reg_q[7];
  assign SHORT_CIRCUIT_DELAY_SEL  = reg_q[8];

  default clocking cb @(posedge CLK); endclocking

  reset_clear_a: assert property (RST |=> reg_q[1] == 8'h00 && ALERT_N && !SDA_OE)
    else $error("reset left state set");
  reg_write_a: assert property (disable iff (RST)
    wr_en && ptr_q == brpr_pkg::SUPPLY_OFS |=> reg_q[2] == $past(sh_q))
    else $error("register write lost");
  unused_zero_a: assert property (disable iff (RST) reg_q[4][7:5] == 3'h0)
    else $error("unused bits set");
  dsg_short_a: assert property (disable iff (RST) CMP.discharge_short |=> flag_q[0])
    else $error("discharge short not flagged");
  chg_short_a: assert property (disable iff (RST) CMP.charge_short |=> flag_q[1])
    else $error("charge short not flagged");
  overload_a: assert property (disable iff (RST) CMP.discharge_overload |=> flag_q[2])
    else $error("overload not flagged");
  overcurrent_a: assert property (disable iff (RST) CMP.charge_overcurrent |=> flag_q[3])
    else $error("overcurrent not flagged");
  brown_read_a: assert property (disable iff (RST)
    status_rd |=> tx_q[4] == $past(CMP.brownout))
    else $error("brownout bit wrong");
  shut_read_a: assert property (disable iff (RST)
    status_rd |=> tx_q[5] == $past(CMP.shutdown) && tx_q[7:6] == 2'h0)
    else $error("shutdown bit wrong");
  alert_hold_a: assert property (disable iff (RST) !ALERT_N && ctrl.latch_release_bit |=> !ALERT_N)
    else $error("alert cleared early");
  latch_hold_a: assert property (disable iff (RST)
    flag_q[2] && !release_p |=> flag_q[2])
    else $error("latch dropped without release");
  fault_fet_a: assert property (disable iff (RST)
    new_event |=> ##1 !DISCHARGE_FET_ON && !CHARGE_FET_ON && !PRECHARGE_FET_OFF)
    else $error("fault left FETs on");
  dsg_drive_a: assert property (disable iff (RST)
    ctrl.discharge_fet_on && !prot && !shut_act |=> DISCHARGE_FET_ON)
    else $error("discharge FET not driven");
  shut_block_a: assert property (disable iff (RST) shut_act |=> !CHARGE_FET_ON)
    else $error("charge FET on in shutdown");
  foreign_nack_a: assert property (disable iff (RST)
    st_q == brpr_pkg::ST_ADDR && scl_fall && !start && !stop && cnt_q == 4'h8
    && sh_q[7:1] != brpr_pkg::SLAVE_ADDR |=> !SDA_OE)
    else $error("foreign address acked");
  ptr_keep_a: assert property (disable iff (RST) wr_en || load |=> ptr_q == $past(ptr_q))
    else $error("pointer moved");

  // Serial slave framing
  addr_ack_a: assert property (disable iff (RST)
    st_q == brpr_pkg::ST_ADDR && scl_fall && !start && !stop && cnt_q == 4'h8
    && sh_q[7:1] == brpr_pkg::SLAVE_ADDR |=> SDA_OE && ack_q)
    else $error("own address not acked");
  gen_call_a: assert property (disable iff (RST)
    st_q == brpr_pkg::ST_ADDR && scl_fall && !start && !stop && cnt_q == 4'h8
    && sh_q[7:1] == 7'h00 |=> !SDA_OE && st_q == brpr_pkg::ST_IDLE)
    else $error("general call acked");
  stop_idle_a: assert property (disable iff (RST)
    stop |=> st_q == brpr_pkg::ST_IDLE && !SDA_OE)
    else $error("stop left slave busy");
  // Bit counter never passes a byte, else the ack slot is missed
  cnt_range_a: assert property (disable iff (RST)
    cnt_q <= 4'h8)
    else $error("bit counter overrun");
  ptr_load_a: assert property (disable iff (RST)
    st_q == brpr_pkg::ST_PTR && scl_fall && !start && !stop && cnt_q == 4'h8
    && !ack_q && !mack_q |=> ptr_q == $past(sh_q))
    else $error("pointer byte not taken");
  wr_ack_a: assert property (disable iff (RST)
    wr_en |=> SDA_OE && st_q == brpr_pkg::ST_WR)
    else $error("data byte not acked");

  // Register contents and decoded fields
  status_wr_a: assert property (disable iff (RST)
    wr_en && ptr_q == brpr_pkg::STATUS_OFS |=> reg_q[1] == $past(reg_q[1])
    && reg_q[2] == $past(reg_q[2]))
    else $error("status write stored");
  rd_zero_a: assert property (disable iff (RST)
    load && ptr_q > brpr_pkg::SC_DLY_OFS |=> tx_q == 8'h00)
    else $error("unmapped read not zero");
  ctrl_fields_a: assert property (disable iff (RST)
    ctrl_wr |=> {SHUTDOWN_MONITOR_DISABLE, THERMISTOR_POWER_ON, LED_DRIVE_ENABLE,
    MONITOR_DISABLE} == $past(sh_q[7:4]))
    else $error("control field lost");
  supply_code_a: assert property (disable iff (RST)
    wr_en && ptr_q == brpr_pkg::SUPPLY_OFS
    |=> {BROWNOUT_THRESHOLD_CODE, SHUTDOWN_THRESHOLD_CODE} == $past(sh_q))
    else $error("supply codes wrong");
  dsg_code_a: assert property (disable iff (RST)
    wr_en && ptr_q == brpr_pkg::DSG_OL_OFS
    |=> DISCHARGE_OVERLOAD_CODE == $past(sh_q[4:0]) && reg_q[3][7:5] == 3'h0)
    else $error("overload code wrong");
  chg_code_a: assert property (disable iff (RST)
    wr_en && ptr_q == brpr_pkg::CHG_OC_OFS
    |=> CHARGE_OVERCURRENT_CODE == $past(sh_q[4:0]) && reg_q[4][7:5] == 3'h0)
    else $error("overcurrent code wrong");

  // Status bits as read by the host
  live_read_a: assert property (disable iff (RST)
    status_rd |=> (tx_q[3:0] & $past(live)) == $past(live))
    else $error("live fault not read");
  clear_read_a: assert property (disable iff (RST)
    status_rd && flag_q == 4'h0 && live == 4'h0 |=> tx_q[3:0] == 4'h0)
    else $error("fault read without cause");

  // Fault latch, alert and FET override
  release_a: assert property (disable iff (RST)
    release_p && live == 4'h0 |=> flag_q == 4'h0)
    else $error("release left flag set");
  flag_only_a: assert property (disable iff (RST)
    !release_p && live == 4'h0 |=> flag_q == $past(flag_q))
    else $error("flag changed without cause");
  for (genvar b = 0; b < 4; b++) begin : g_flag_chk
    flag_keep_a: assert property (disable iff (RST)
      flag_q[b] && !release_p |=> flag_q[b])
      else $error("fault flag dropped");
  end
  alert_set_a: assert property (disable iff (RST) new_event |=> !ALERT_N)
    else $error("alert not raised");
  alert_keep_a: assert property (disable iff (RST)
    !ALERT_N && !status_rd |=> !ALERT_N)
    else $error("alert cleared without read");
  alert_clear_a: assert property (disable iff (RST)
    alert_clr && !new_event |=> ALERT_N)
    else $error("alert not cleared");
  latch_fet_a: assert property (disable iff (RST)
    prot |=> !DISCHARGE_FET_ON && !CHARGE_FET_ON && !PRECHARGE_FET_OFF)
    else $error("latched fault left FETs on");
  chg_drive_a: assert property (disable iff (RST)
    ctrl.charge_fet_on && !prot && !shut_act |=> CHARGE_FET_ON)
    else $error("charge FET not driven");
  precharge_fet_off_on_a: assert property (disable iff (RST)
    !ctrl.precharge_fet_off |=> !PRECHARGE_FET_OFF)
    else $error("precharge FET not on");
  precharge_fet_off_off_a: assert property (disable iff (RST)
    ctrl.precharge_fet_off && !prot |=> PRECHARGE_FET_OFF)
    else $error("precharge FET not off");
  dsg_shut_a: assert property (disable iff (RST) shut_act |=> !DISCHARGE_FET_ON)
    else $error("discharge FET on in shutdown");

  ctrl_write_c: cover property (disable iff (RST) ctrl_wr);
  status_read_c: cover property (disable iff (RST) status_rd);
  release_c: cover property (disable iff (RST) release_p && prot);
  alert_clear_c: cover property (disable iff (RST) alert_q && alert_clr);
  fault_event_c: cover property (disable iff (RST) new_event);
endmodule
`default_nettype wire

// ---- shared/brpr_pkg.sv ----
// Constants and types for the battery protector register bank
`default_nettype none
package brpr_pkg;
  localparam logic [6:0] SLAVE_ADDR   = 7'h20;
  localparam logic [7:0] STATUS_OFS   = 8'h00;
  localparam logic [7:0] CONTROL_OFS  = 8'h01;
  localparam logic [7:0] SUPPLY_OFS   = 8'h02;
  localparam logic [7:0] DSG_OL_OFS   = 8'h03;
  localparam logic [7:0] CHG_OC_OFS   = 8'h04;
  localparam logic [7:0] OC_DLY_OFS   = 8'h05;
  localparam logic [7:0] CELL_OFS     = 8'h06;
  localparam logic [7:0] SC_LVL_OFS   = 8'h07;
  localparam logic [7:0] SC_DLY_OFS   = 8'h08;
  localparam logic [7:0] RESET_VAL    = 8'h00;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int         SHUT_LSB     = 0;
  localparam int         BROWN_LSB    = 4;
  localparam logic [7:0] WR_MASK [1:8] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F,
                                            8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Comparator levels, ordered as status bits five down to zero
  typedef struct packed {
    logic shutdown;
    logic brownout;
    logic charge_overcurrent;
    logic discharge_overload;
    logic charge_short;
    logic discharge_short;
  } brpr_cmp_t;

  typedef struct packed {
    logic shutdown_monitor_disable;
    logic thermistor_power_on;
    logic led_drive_enable;
    logic monitor_disable;
    logic precharge_fet_off;
    logic charge_fet_on;
    logic discharge_fet_on;
    logic latch_release_bit;
  } brpr_ctrl_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD} brpr_state_t;
endpackage
`default_nettype wire

// ---- verification/brpr_host.sv ----
// Serial link host model that drives the register bank
`timescale 1ns/100ps
`default_nettype none
module brpr_host (
  // Clock
  input  wire logic clk,
  // Serial link, data level resolved outside
  input  wire logic sda,
  output logic      scl,
  output logic      sda_h
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Four clocks a phase keeps every level over four samples
  task automatic tick();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    sda_h = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_h = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_h = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_h = 1'b1;
    tick();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q,
                         output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m, k);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic [2:0] nk);
    logic [7:0] q;
    start();
    byte_io({a, 1'b0}, 1'b1, q, nk[2]);
    byte_io(p, 1'b1, q, nk[1]);
    byte_io(d, 1'b1, q, nk[0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({brpr_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    byte_io(p, 1'b1, q, k);
    start();
    byte_io({brpr_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    byte_io(8'hFF, 1'b0, d0, k);
    byte_io(8'hFF, 1'b1, d1, k);
    stop();
  endtask
endmodule
`default_nettype wire

// ---- verification/brpr_bank_test.sv ----
// Self-checking bench for the battery protector register bank
`timescale 1ns/100ps
`default_nettype none
module brpr_bank_test;
  localparam logic [7:0] WV [10] = '{8'hFF, 8'h78, 8'hA5, 8'hFF, 8'hEA, 8'h3C, 8'hC3,
                                     8'h5A, 8'h96, 8'hFF};
  localparam logic [7:0] EV [10] = '{8'h00, 8'h78, 8'hA5, 8'h1F, 8'h0A, 8'h3C, 8'hC3,
                                     8'h5A, 8'h96, 8'h00};
  localparam logic [6:0] ADR = brpr_pkg::SLAVE_ADDR;
  logic                clk, rst, scl, sda_h;
  wire logic           sda_oe, alert_n;
  wire logic [6:0]     outs;
  wire logic [7:0]     supply_threshold_select, overcurrent_delay_select, mbs, short_circuit_level, short_circuit_delay_select;
  wire logic [4:0]     dol, coc;
  brpr_pkg::brpr_cmp_t cmp;
  int                  err_count, compares;
  // Open drain data line with pull-up
  wire logic           sda_w = sda_h & ~sda_oe;

  brpr_bank dut_u (
    .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe),
    .CMP(cmp), .ALERT_N(alert_n), .DISCHARGE_FET_ON(outs[0]), .CHARGE_FET_ON(outs[1]),
    .PRECHARGE_FET_OFF(outs[2]), .MONITOR_DISABLE(outs[3]), .LED_DRIVE_ENABLE(outs[4]),
    .THERMISTOR_POWER_ON(outs[5]), .SHUTDOWN_MONITOR_DISABLE(outs[6]),
    .SHUTDOWN_THRESHOLD_CODE(supply_threshold_select[3:0]), .BROWNOUT_THRESHOLD_CODE(supply_threshold_select[7:4]),
    .DISCHARGE_OVERLOAD_CODE(dol), .CHARGE_OVERCURRENT_CODE(coc),
    .OVERCURRENT_DELAY_SEL(overcurrent_delay_select), .MONITOR_BALANCE_SEL(mbs), .SHORT_CIRCUIT_LEVEL(short_circuit_level),
    .SHORT_CIRCUIT_DELAY_SEL(short_circuit_delay_select)
  );
  brpr_host host_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_h(sda_h));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    compares++;
    if (got !== ex) begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      err_count++;
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] d0, d1;
    for (int i = 0; i < 9; i++) begin
      host_u.rd(8'(i), d0, d1);
      chk("reset value", 8'h00, d0);
    end
    chk("reset outputs", 8'h80, {alert_n, outs});
    chk("reset codes", 8'h00, supply_threshold_select | overcurrent_delay_select | mbs | short_circuit_level | short_circuit_delay_select | {3'h0, dol | coc});
  endtask
  task automatic t_regs();
    logic [7:0] d0, d1;
    logic [2:0] nk;
    for (int i = 0; i < 10; i++) begin
      host_u.wr(ADR, 8'(i), WV[i], nk);
      chk("write ack", 8'h00, {5'h0, nk});
      host_u.rd(8'(i), d0, d1);
      chk("readback", EV[i], d0);
      chk("repeat read", EV[i], d1);
    end
    chk("shutdown code", 8'h05, {4'h0, supply_threshold_select[3:0]});
    chk("brownout code", 8'h0A, {4'h0, supply_threshold_select[7:4]});
    chk("overload code", 8'h1F, {3'h0, dol});
    chk("overcurrent code", 8'h0A, {3'h0, coc});
    chk("delay select", 8'h3C, overcurrent_delay_select);
    chk("balance select", 8'hC3, mbs);
    chk("short level", 8'h5A, short_circuit_level);
    chk("short delay", 8'h96, short_circuit_delay_select);
  endtask
  task automatic t_ctrl();
    logic [2:0] nk;
    for (int i = 1; i < 8; i++) begin
      host_u.wr(ADR, 8'h01, 8'h01 << i, nk);
      chk("control outputs", 8'h01 << (i - 1), {1'b0, outs});
    end
  endtask
  task automatic t_shut();
    logic [7:0] d0, d1;
    logic [2:0] nk;
    cmp = 6'h30;
    host_u.wr(ADR, 8'h01, 8'h06, nk);
    chk("fets in shutdown", 8'h00, {1'b0, outs});
    host_u.rd(8'h00, d0, d1);
    chk("supply status", 8'h30, d0);
    host_u.wr(ADR, 8'h01, 8'h86, nk);
    chk("monitor off", 8'h43, {1'b0, outs});
    cmp = '0;
    host_u.wr(ADR, 8'h01, 8'h00, nk);
  endtask
  task automatic t_fault();
    logic [7:0] d0, d1;
    logic [2:0] nk;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(ADR, 8'h01, 8'h0E, nk);
      chk("fets before fault", 8'h07, {1'b0, outs});
      cmp = 6'(1 << i);
      repeat (3) @(negedge clk);
      cmp = '0;
      repeat (2) @(negedge clk);
      chk("fault outputs", 8'h00, {alert_n, outs});
      host_u.rd(8'h00, d0, d1);
      chk("latched flag", 8'(1 << i), d0);
      chk("alert held", 8'h00, {7'h0, alert_n});
      host_u.wr(ADR, 8'h01, 8'h0F, nk);
      host_u.rd(8'h00, d0, d1);
      chk("alert with bit set", 8'(1 << i), {alert_n, d0[6:0]});
      host_u.wr(ADR, 8'h01, 8'h0E, nk);
      chk("after release", 8'h07, {alert_n, outs});
      host_u.rd(8'h00, d0, d1);
      chk("alert cleared", 8'h80, {alert_n, d0[6:0]});
    end
  endtask
  task automatic t_addr();
    logic [7:0] d0, d1;
    logic [2:0] nk;
    for (int i = 0; i < 2; i++) begin
      host_u.wr(i == 0 ? 7'h00 : 7'h21, 8'h02, 8'h00, nk);
      chk("foreign address", 8'h07, {5'h0, nk});
      host_u.rd(8'h02, d0, d1);
      chk("register kept", 8'hA5, d0);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    cmp = '0;
    err_count = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_addr();
    t_ctrl();
    t_shut();
    t_fault();
    test_done();
  end
  // Hang guard; the full sequence needs well under this
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
